/* hw/quad_pot_pkg.sv */
`default_nettype none
package quad_pot_pkg;
	// frame field layout
	localparam int BYTE_W        = 8;
	localparam int POTS          = 4;
	localparam int SETTINGS      = 4;
	localparam int TAPS          = 256;
	localparam logic [3:0] DEVICE_TYPE_ID = 4'h6;  // device-type nibble; value is arbitrary
	localparam logic [1:0] ADDR_ZERO_BITS = 2'h0;
	// instruction opcodes
	localparam logic [3:0] OP_READ_WIPER    = 4'h9;
	localparam logic [3:0] OP_WRITE_WIPER   = 4'hA;
	localparam logic [3:0] OP_READ_SETTING  = 4'hB;
	localparam logic [3:0] OP_WRITE_SETTING = 4'hC;
	localparam logic [3:0] OP_SET_TO_WIPER  = 4'hD;
	localparam logic [3:0] OP_WIPER_TO_SET  = 4'hE;
	localparam logic [3:0] OP_GLOBAL_TO_WIP = 4'h1;
	localparam logic [3:0] OP_GLOBAL_TO_SET = 4'h8;
	localparam logic [3:0] OP_STEP          = 4'h2;
	localparam logic [3:0] OP_STATUS        = 4'h5;
	localparam logic [1:0] FIELD_ZERO       = 2'h0;
	localparam logic [1:0] STATUS_POT       = 2'h1;
	// reset value of stored settings in this model
	localparam logic [7:0] SETTING_RESET    = 8'h80;
	localparam logic [7:0] WIPER_MIN        = 8'h00;
	localparam logic [7:0] WIPER_MAX        = 8'hFF;
	// nonvolatile write time
	localparam int NV_WRITE_MS  = 5;
	localparam int CLK_HZ       = 125_000_000;
	localparam int NV_WRITE_CYC = NV_WRITE_MS * (CLK_HZ / 1000);
endpackage
`default_nettype wire

/* hw/quad_pot_serial_command_unit.sv */
// Contract
// - four volatile 8-bit wiper registers
// - wiper value decoded to one-hot tap
// - wipers load first setting at power-up
// - four nonvolatile settings per pot
// - setting write completes within 5 ms
// - nonvolatile save starts at chip-select high
// - status bit high while write runs
// - opcode 1001 reads selected wiper
// - opcode 1010 writes selected wiper
// - opcode 1011 reads addressed setting
// - opcode 1100 writes addressed setting
// - opcode 1101 copies setting to wiper
// - opcode 1110 copies wiper to setting
// - opcode 0001 copies settings to all wipers
// - opcode 1000 copies all wipers to settings
// - opcode 0010 enters step mode
// - opcode 0101 returns write status
// - step mode moves wiper per clock
// - read/write/status frames are three bytes
// - transfer frames are two bytes
// - address byte type, zeros, pin address
// - instruction byte opcode, setting, pot fields
`default_nettype none
module quad_pot_serial_command_unit
	import quad_pot_pkg::*;
#(
	parameter int NV_WRITE_CYCLES = quad_pot_pkg::NV_WRITE_CYC
) (
	input  wire logic                   clk_sys,
	input  wire logic                   nrst,
	input  wire logic                   sck,
	input  wire logic                   cs_n,
	input  wire logic                   si,
	input  wire logic [1:0]             pin_address,
	output logic                        so,
	output logic                        so_oe,
	output logic [quad_pot_pkg::TAPS-1:0] tap_select_0,
	output logic [quad_pot_pkg::TAPS-1:0] tap_select_1,
	output logic [quad_pot_pkg::TAPS-1:0] tap_select_2,
	output logic [quad_pot_pkg::TAPS-1:0] tap_select_3,
	output logic                        write_in_progress
);
	import quad_pot_pkg::*;

	// block overview
	// two clock domains live here: the link side runs on sck and the
	// register side on clk_sys. sck only moves inside frames, so the
	// link side cannot rely on clk_sys for anything and is cleared by
	// chip select high between frames.
	// commands cross as a toggle plus a payload that is held still
	// until the next committed frame ends; the register side sees the toggle after
	// two flops and only then reads the payload, so no word is torn.
	// step pulses cross the same way, one toggle per sck rise. the host
	// must space step pulses wider than the toggle resync, otherwise two
	// toggles cancel into no edge and both steps are lost.
	// read data goes the other way through snapshots that are frozen
	// while chip select is low, so a read never sees a half-updated
	// register.
	// the toggle flops must never be cleared by chip select: a clear
	// between frames would itself look like an edge on the far side.
	// they are cleared only by the system reset.
	// limitation: so is resynced to clk_sys and lags the sck fall by a
	// few clk_sys cycles, so the host must not run sck too fast for a
	// read.
	// nonvolatile storage is held in flops, reset to a fixed value;
	// the write timer only models how long the busy flag stands.

	typedef enum logic [4:0] {
		ST_ADDR  = 5'b0_0001,
		ST_INSTR = 5'b0_0010,
		ST_DATA  = 5'b0_0100,
		ST_STEP  = 5'b0_1000,
		ST_IGNORE = 5'b1_0000
	} frame_state_t;

	// ---------------- link domain (sck) ----------------
	// link frame logic is reset by chip select, since sck only runs inside frames
	frame_state_t      fstate_reg;
	logic [2:0]        bitcnt_reg;
	logic [6:0]        shift_reg;
	logic [7:0]        instr_reg;
	logic [7:0]        rx_byte;
	logic              byte_done;
	logic [7:0]        tx_reg;
	logic              so_drive_reg;
	// link to system requests as toggles with held payload
	logic              req_tgl_reg;
	logic [3:0]        req_op_reg;
	logic [1:0]        req_set_reg;
	logic [1:0]        req_pot_reg;
	logic [7:0]        req_data_reg;
	logic              step_tgl_reg;
	logic              step_up_reg;
	logic [1:0]        step_pot_reg;

	assign rx_byte   = {shift_reg, si};
	assign byte_done = (bitcnt_reg == 3'd7);

	// readback snapshots from system domain, stable while frames run
	logic [7:0] wiper_q [POTS];
	logic [7:0] setting_q [POTS][SETTINGS];
	logic       busy_q;

	function automatic logic is_three_byte(input logic [3:0] op);
		return op == OP_READ_WIPER || op == OP_WRITE_WIPER || op == OP_READ_SETTING ||
		       op == OP_WRITE_SETTING || op == OP_STATUS;
	endfunction

	// decide what leaves on so for read instructions
	function automatic logic [7:0] read_value(input logic [7:0] ins);
		unique case (ins[7:4])
			OP_READ_WIPER:   return wiper_q[ins[1:0]];
			OP_READ_SETTING: return setting_q[ins[1:0]][ins[3:2]];
			OP_STATUS:       return {7'h00, busy_q};
			default:         return 8'h00;
		endcase
	endfunction

	// receive path: sample si on rising sck, msb first
	always_ff @(posedge sck or posedge cs_n) begin
		if (cs_n) begin
			fstate_reg <= ST_ADDR;
			bitcnt_reg <= 3'd0;
			shift_reg  <= 7'h00;
			instr_reg  <= 8'h00;
		end else begin
			bitcnt_reg <= bitcnt_reg + 3'd1;
			shift_reg  <= rx_byte[6:0];
			if (byte_done) begin
				unique case (fstate_reg)
					ST_ADDR:
						if (rx_byte[7:4] == DEVICE_TYPE_ID && rx_byte[3:2] == ADDR_ZERO_BITS &&
						    rx_byte[1:0] == pin_address)
							fstate_reg <= ST_INSTR;
						else
							fstate_reg <= ST_IGNORE;
					ST_INSTR: begin
						instr_reg <= rx_byte;
						if (rx_byte[7:4] == OP_STEP && rx_byte[3:2] == FIELD_ZERO)
							fstate_reg <= ST_STEP;
						else if (is_three_byte(rx_byte[7:4]))
							fstate_reg <= ST_DATA;
						else
							fstate_reg <= ST_IGNORE;
					end
					ST_STEP:  fstate_reg <= ST_STEP;
					default:  fstate_reg <= ST_IGNORE;
				endcase
			end
		end
	end

	// step pulses go out as toggles, one per sck rise
	// cleared by system reset only, so chip select never fakes an edge
	always_ff @(posedge sck or negedge nrst) begin
		if (!nrst) begin
			step_tgl_reg <= 1'b0;
			step_up_reg  <= 1'b0;
			step_pot_reg <= 2'h0;
		end else if (!cs_n && fstate_reg == ST_STEP) begin
			step_tgl_reg <= ~step_tgl_reg;
			step_up_reg  <= si;
			step_pot_reg <= instr_reg[1:0];
		end
	end

	// posted command: latched at frame end, committed by chip select rising
	logic        cmd_pend_reg;
	logic [3:0]  cmd_op_reg;
	logic [1:0]  cmd_set_reg;
	logic [1:0]  cmd_pot_reg;
	logic [7:0]  cmd_data_reg;
	logic        cmd_pend_sync;
	always_ff @(posedge sck or posedge cs_n) begin
		if (cs_n) begin
			cmd_pend_reg <= 1'b0;
		end else if (fstate_reg == ST_INSTR && byte_done && !is_three_byte(rx_byte[7:4])) begin
			cmd_pend_reg <= 1'b1;
			cmd_op_reg   <= rx_byte[7:4];
			cmd_set_reg  <= rx_byte[3:2];
			cmd_pot_reg  <= rx_byte[1:0];
			cmd_data_reg <= 8'h00;
		end else if (fstate_reg == ST_DATA && byte_done) begin
			cmd_pend_reg <= 1'b1;
			cmd_op_reg   <= instr_reg[7:4];
			cmd_set_reg  <= instr_reg[3:2];
			cmd_pot_reg  <= instr_reg[1:0];
			cmd_data_reg <= rx_byte;
		end else begin
			// any bit beyond the frame's end voids the command
			cmd_pend_reg <= 1'b0;
		end
	end
	assign cmd_pend_sync = cmd_pend_reg;

	// chip select rising hands the command over
	// payload is held from here until the next committed frame
	always_ff @(posedge cs_n or negedge nrst) begin
		if (!nrst) begin
			req_tgl_reg  <= 1'b0;
			req_op_reg   <= 4'h0;
			req_set_reg  <= 2'h0;
			req_pot_reg  <= 2'h0;
			req_data_reg <= 8'h00;
		end else if (cmd_pend_sync) begin
			req_tgl_reg  <= ~req_tgl_reg;
			req_op_reg   <= cmd_op_reg;
			req_set_reg  <= cmd_set_reg;
			req_pot_reg  <= cmd_pot_reg;
			req_data_reg <= cmd_data_reg;
		end
	end

	// transmit path: change so on falling sck
	always_ff @(negedge sck or posedge cs_n) begin
		if (cs_n) begin
			tx_reg       <= 8'h00;
			so_drive_reg <= 1'b0;
		end else if (fstate_reg == ST_DATA && bitcnt_reg == 3'd0) begin
			tx_reg       <= read_value(instr_reg);
			so_drive_reg <= instr_reg[7:4] == OP_READ_WIPER ||
			                instr_reg[7:4] == OP_READ_SETTING || instr_reg[7:4] == OP_STATUS;
		end else if (fstate_reg == ST_DATA) begin
			tx_reg <= {tx_reg[6:0], 1'b0};
		end else begin
			so_drive_reg <= 1'b0;
		end
	end

	// ---------------- system domain ----------------
	logic [2:0] req_sync_reg;
	logic [2:0] step_sync_reg;
	logic [1:0] cs_sync_reg;
	logic [1:0] so_sync_reg;
	logic [1:0] oe_sync_reg;
	// one volatile wiper per pot
	logic [7:0] wiper_reg [POTS];
	// nonvolatile settings, four per pot
	logic [7:0] setting_reg [POTS][SETTINGS];
	// set once the power-up recall has been done
	logic       loaded_reg;
	logic [$clog2(NV_WRITE_CYCLES+1)-1:0] nv_cnt_reg;
	logic       req_evt;
	logic       step_evt;
	logic       nv_start;

	// toggle crossings, three stages so edges are seen after two flops; cs_n, so and oe levels take two stages
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			req_sync_reg  <= 3'b000;
			step_sync_reg <= 3'b000;
			cs_sync_reg   <= 2'b11;
			so_sync_reg   <= 2'b00;
			oe_sync_reg   <= 2'b00;
		end else begin
			req_sync_reg  <= {req_sync_reg[1:0], req_tgl_reg};
			step_sync_reg <= {step_sync_reg[1:0], step_tgl_reg};
			cs_sync_reg   <= {cs_sync_reg[0], cs_n};
			so_sync_reg   <= {so_sync_reg[0], tx_reg[7]};
			oe_sync_reg   <= {oe_sync_reg[0], so_drive_reg};
		end
	end
	assign req_evt  = req_sync_reg[2] ^ req_sync_reg[1];
	assign step_evt = step_sync_reg[2] ^ step_sync_reg[1];
	assign nv_start = req_evt && (req_op_reg == OP_WRITE_SETTING ||
	                  req_op_reg == OP_WIPER_TO_SET ||
	                  (req_op_reg == OP_GLOBAL_TO_SET && req_pot_reg == FIELD_ZERO));

	// stored settings; nonvolatile array held in flops here
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			for (int p = 0; p < POTS; p++)
				for (int s = 0; s < SETTINGS; s++)
					setting_reg[p][s] <= SETTING_RESET;
		end else if (req_evt) begin
			unique case (req_op_reg)
				OP_WRITE_SETTING: setting_reg[req_pot_reg][req_set_reg] <= req_data_reg;
				OP_WIPER_TO_SET:  setting_reg[req_pot_reg][req_set_reg] <= wiper_reg[req_pot_reg];
				OP_GLOBAL_TO_SET:
					if (req_pot_reg == FIELD_ZERO)
						for (int p = 0; p < POTS; p++)
							setting_reg[p][req_set_reg] <= wiper_reg[p];
				default: ;
			endcase
		end
	end

	// wipers: power-up recall, host writes, transfers and steps
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			loaded_reg <= 1'b0;
			for (int p = 0; p < POTS; p++)
				wiper_reg[p] <= WIPER_MIN;
		end else if (!loaded_reg) begin
			loaded_reg <= 1'b1;
			for (int p = 0; p < POTS; p++)
				wiper_reg[p] <= setting_reg[p][0];
		end else if (req_evt) begin
			unique case (req_op_reg)
				OP_WRITE_WIPER:
					if (req_set_reg == FIELD_ZERO)
						wiper_reg[req_pot_reg] <= req_data_reg;
				OP_SET_TO_WIPER: wiper_reg[req_pot_reg] <= setting_reg[req_pot_reg][req_set_reg];
				OP_GLOBAL_TO_WIP:
					if (req_pot_reg == FIELD_ZERO)
						for (int p = 0; p < POTS; p++)
							wiper_reg[p] <= setting_reg[p][req_set_reg];
				default: ;
			endcase
		end else if (step_evt) begin
			if (step_up_reg && wiper_reg[step_pot_reg] != WIPER_MAX)
				wiper_reg[step_pot_reg] <= wiper_reg[step_pot_reg] + 8'h01;
			else if (!step_up_reg && wiper_reg[step_pot_reg] != WIPER_MIN)
				wiper_reg[step_pot_reg] <= wiper_reg[step_pot_reg] - 8'h01;
		end
	end

	// nonvolatile write timer; busy must cover the whole cycle
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			nv_cnt_reg        <= '0;
			write_in_progress <= 1'b0;
		end else if (nv_start) begin
			nv_cnt_reg        <= ($bits(nv_cnt_reg))'(NV_WRITE_CYCLES - 1);
			write_in_progress <= 1'b1;
		end else if (nv_cnt_reg != '0) begin
			nv_cnt_reg <= nv_cnt_reg - 1'b1;
		end else begin
			write_in_progress <= 1'b0;
		end
	end

	// snapshots read by the link; only updated while chip select is high
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			busy_q <= 1'b0;
		end else if (cs_sync_reg[1]) begin
			busy_q <= write_in_progress;
			for (int p = 0; p < POTS; p++) begin
				wiper_q[p] <= wiper_reg[p];
				for (int s = 0; s < SETTINGS; s++)
					setting_q[p][s] <= setting_reg[p][s];
			end
		end
	end

	// tap decode, one-hot per pot
	// registered so the tap switches never see decode glitches
	// so and so_oe leave from flops as well, after the resync
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			tap_select_0 <= '0;
			tap_select_1 <= '0;
			tap_select_2 <= '0;
			tap_select_3 <= '0;
			so           <= 1'b0;
			so_oe        <= 1'b0;
		end else begin
			tap_select_0 <= TAPS'(1) << wiper_reg[0];
			tap_select_1 <= TAPS'(1) << wiper_reg[1];
			tap_select_2 <= TAPS'(1) << wiper_reg[2];
			tap_select_3 <= TAPS'(1) << wiper_reg[3];
			so           <= so_sync_reg[1];
			so_oe        <= oe_sync_reg[1];
		end
	end
endmodule // quad_pot_serial_command_unit
`default_nettype wire

/* verification/quad_pot_props.sv */
`default_nettype none
module quad_pot_props
	import quad_pot_pkg::*;
#(
	parameter int NV_WRITE_CYCLES = 50
) (
	input wire logic            clk_sys,
	input wire logic            nrst,
	input wire logic            cs_n,
	input wire logic            so_oe,
	input wire logic [TAPS-1:0] tap_select_0,
	input wire logic [TAPS-1:0] tap_select_1,
	input wire logic [TAPS-1:0] tap_select_2,
	input wire logic [TAPS-1:0] tap_select_3,
	input wire logic            write_in_progress
);
	int busy_cnt;
	// length of the running busy stretch
	always_ff @(posedge clk_sys) begin
		if (!nrst || !write_in_progress) busy_cnt <= 0;
		else busy_cnt <= busy_cnt + 1;
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	property p_tap_onehot;
		nrst && $past(nrst, 5) |-> $onehot(tap_select_0) && $onehot(tap_select_1)
			&& $onehot(tap_select_2) && $onehot(tap_select_3);
	endproperty
	a_tap_onehot: assert property (p_tap_onehot) else $error("tap not one-hot");
	property p_reset_load;
		$rose(nrst) |-> ##[1:6] (tap_select_0[128] && tap_select_1[128]
			&& tap_select_2[128] && tap_select_3[128]);
	endproperty
	a_reset_load: assert property (p_reset_load) else $error("no load at start");
	// checked inside reset too, so no disable here
	property p_reset_quiet;
		disable iff (1'b0) !nrst |=> !write_in_progress && !so_oe;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("busy in reset");
	property p_wip_length;
		$fell(write_in_progress) |-> busy_cnt == NV_WRITE_CYCLES;
	endproperty
	a_wip_length: assert property (p_wip_length) else $error("write time wrong");
	property p_wip_bound;
		busy_cnt <= NV_WRITE_CYCLES;
	endproperty
	a_wip_bound: assert property (p_wip_bound) else $error("write too long");
	property p_wip_commit;
		$rose(write_in_progress) |-> cs_n && $past(cs_n, 2);
	endproperty
	a_wip_commit: assert property (p_wip_commit) else $error("write inside frame");
	property p_oe_idle;
		cs_n [*6] |-> !so_oe;
	endproperty
	a_oe_idle: assert property (p_oe_idle) else $error("so driven when idle");
	property p_taps_idle;
		cs_n [*8] |-> $stable(tap_select_0) && $stable(tap_select_1)
			&& $stable(tap_select_2) && $stable(tap_select_3);
	endproperty
	a_taps_idle: assert property (p_taps_idle) else $error("tap moved idle");
	c_write: cover property ($rose(write_in_progress));
	c_read: cover property ($rose(so_oe));
	c_move: cover property (!$stable(tap_select_0));
endmodule // quad_pot_props
bind quad_pot_serial_command_unit quad_pot_props #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) props_inst (
	.clk_sys(clk_sys), .nrst(nrst), .cs_n(cs_n), .so_oe(so_oe),
	.tap_select_0(tap_select_0), .tap_select_1(tap_select_1),
	.tap_select_2(tap_select_2), .tap_select_3(tap_select_3),
	.write_in_progress(write_in_progress));
`default_nettype wire

/* verification/spi_host_model.sv */
`default_nettype none
module spi_host_model (
	output logic     sck,
	output logic     cs_n,
	output logic     si,
	input wire logic so
);
	timeunit 1ns;
	timeprecision 100ps;
	logic lclk;
	// free base clock; sck itself only moves inside frames
	initial begin
		lclk = 1'b0;
		sck = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
		#7;
		forever #15 lclk = ~lclk;
	end
	// half sck period of two base cycles leaves room for the so resync lag
	task automatic xfer(input logic [31:0] bits, input int n, output logic [7:0] rd);
		rd = 8'h00;
		@(posedge lclk);
		cs_n = 1'b0;
		for (int i = 0; i < n; i++) begin
			si = bits[31-i];
			repeat (2) @(posedge lclk);
			sck = 1'b1;
			if (i >= 16 && i < 24) rd = {rd[6:0], so};
			repeat (2) @(posedge lclk);
			sck = 1'b0;
		end
		repeat (2) @(posedge lclk);
		cs_n = 1'b1;
		si = ~si; // si inverted after the frame, so no stale level carries over
		repeat (4) @(posedge lclk);
	endtask
endmodule // spi_host_model
`default_nettype wire

/* verification/tb_top.sv */
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import quad_pot_pkg::*;
	localparam logic [1:0] PA = 2'h2;
	localparam logic [TAPS-1:0] TAP0 = {{(TAPS-1){1'b0}}, 1'b1};
	logic            clk_sys, nrst, sck, cs_n, si, so, so_oe, write_in_progress;
	logic [1:0]      pin_address;
	logic [TAPS-1:0] taps [POTS];
	logic [7:0]      rd, addr_byte;
	int              mismatches, checked, cycles;
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	quad_pot_serial_command_unit #(.NV_WRITE_CYCLES(600)) quad_pot_serial_command_unit_inst (
		.clk_sys(clk_sys), .nrst(nrst), .sck(sck), .cs_n(cs_n), .si(si),
		.pin_address(pin_address), .so(so), .so_oe(so_oe),
		.tap_select_0(taps[0]), .tap_select_1(taps[1]), .tap_select_2(taps[2]),
		.tap_select_3(taps[3]), .write_in_progress(write_in_progress));
	spi_host_model spi_host_model_inst (.sck(sck), .cs_n(cs_n), .si(si), .so(so));
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic check(input logic [TAPS-1:0] seen, input logic [TAPS-1:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: saw %0h want %0h", $time, seen, exp);
		end
	endtask
	task automatic frame(input logic [3:0] op, input logic [1:0] rs, input logic [1:0] ps,
		input logic [7:0] d, input int n);
		spi_host_model_inst.xfer({addr_byte, op, rs, ps, d, 8'h00}, n, rd);
	endtask
	task automatic read_wiper(input logic [1:0] p, input logic [7:0] e);
		frame(OP_READ_WIPER, FIELD_ZERO, p, 8'h00, 24);
		check(rd, e);
		check(taps[p], TAP0 << e);
	endtask
	// first poll must still see the write busy
	task automatic wait_idle;
		frame(OP_STATUS, FIELD_ZERO, STATUS_POT, 8'h00, 24);
		check(rd, 8'h01);
		for (int k = 0; k < 40 && rd !== 8'h00; k++)
			frame(OP_STATUS, FIELD_ZERO, STATUS_POT, 8'h00, 24);
		check(rd, 8'h00);
	endtask
	task automatic s_start;
		for (int p = 0; p < POTS; p++) read_wiper(p[1:0], SETTING_RESET);
		check(write_in_progress, 1'b0);
	endtask
	task automatic s_wipers;
		for (int p = 0; p < POTS; p++) frame(OP_WRITE_WIPER, FIELD_ZERO, p[1:0], 8'h40 + p[7:0], 24);
		for (int p = 0; p < POTS; p++) read_wiper(p[1:0], 8'h40 + p[7:0]);
	endtask
	task automatic s_setting;
		frame(OP_WRITE_SETTING, 2'h3, 2'h1, 8'hA5, 24);
		check(write_in_progress, 1'b1);
		wait_idle();
		frame(OP_READ_SETTING, 2'h3, 2'h1, 8'h00, 24);
		check(rd, 8'hA5);
		frame(OP_READ_SETTING, 2'h2, 2'h1, 8'h00, 24);
		check(rd, SETTING_RESET);
		frame(OP_SET_TO_WIPER, 2'h3, 2'h1, 8'h00, 16);
		check(write_in_progress, 1'b0);
		read_wiper(2'h1, 8'hA5);
	endtask
	task automatic s_transfers;
		frame(OP_WIPER_TO_SET, 2'h2, 2'h3, 8'h00, 16);
		wait_idle();
		frame(OP_READ_SETTING, 2'h2, 2'h3, 8'h00, 24);
		check(rd, 8'h43);
		frame(OP_GLOBAL_TO_SET, 2'h1, FIELD_ZERO, 8'h00, 16);
		wait_idle();
		for (int p = 0; p < POTS; p++) frame(OP_WRITE_WIPER, FIELD_ZERO, p[1:0], 8'h0F, 24);
		frame(OP_GLOBAL_TO_WIP, 2'h1, FIELD_ZERO, 8'h00, 16);
		for (int p = 0; p < POTS; p++)
			read_wiper(p[1:0], (p == 1) ? 8'hA5 : 8'h40 + p[7:0]);
	endtask
	task automatic step(input logic [7:0] start, input logic up, input int n, input logic [7:0] e);
		frame(OP_WRITE_WIPER, FIELD_ZERO, 2'h0, start, 24);
		frame(OP_STEP, FIELD_ZERO, 2'h0, {8{up}}, 16 + n);
		read_wiper(2'h0, e);
	endtask
	// each broken frame must leave pot 0 untouched
	task automatic s_refuse;
		addr_byte = {DEVICE_TYPE_ID, ADDR_ZERO_BITS, ~PA};
		frame(OP_WRITE_WIPER, FIELD_ZERO, 2'h0, 8'h99, 24);
		addr_byte = {DEVICE_TYPE_ID, 2'h1, PA};
		frame(OP_WRITE_WIPER, FIELD_ZERO, 2'h0, 8'h99, 24);
		addr_byte = {DEVICE_TYPE_ID, ADDR_ZERO_BITS, PA};
		frame(OP_WRITE_WIPER, FIELD_ZERO, 2'h0, 8'h99, 23);
		frame(OP_WRITE_WIPER, FIELD_ZERO, 2'h0, 8'h99, 25);
		frame(4'hF, FIELD_ZERO, 2'h0, 8'h99, 24);
		read_wiper(2'h0, 8'h53);
	endtask
	// hang guard, well above the length of the sequence
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 60000) begin
			mismatches++;
			give_verdict();
		end
	end
	initial begin
		nrst = 1'b0;
		pin_address = PA;
		addr_byte = {DEVICE_TYPE_ID, ADDR_ZERO_BITS, PA};
		repeat (5) @(negedge clk_sys);
		nrst = 1'b1;
		repeat (8) @(negedge clk_sys);
		s_start();
		s_wipers();
		s_setting();
		s_transfers();
		step(8'hFD, 1'b1, 5, 8'hFF);
		step(8'h03, 1'b0, 6, 8'h00);
		step(8'h50, 1'b1, 3, 8'h53);
		s_refuse();
		give_verdict();
	end
endmodule // tb_top
`default_nettype wire
